//--- rtl/ipw_defines.svh
// Register map, field positions and reset values of the inverter PWM timer
// Contract
// - 16-bit counter, up or up-down by mode
// - Counter clears to zero on reset
// - Clear-on-period modes clear at period match
// - Symmetric triangle: copy buffers at turnaround
// - Asymmetric triangle: copy at turnaround and period
// - Sawtooth and mode one: up, clear, copy
// - Counter read whole, writes ignored
// - Three 10-bit one-shot dead-time down counters
// - Only enable bit gates dead-time counting
// - Phase match loads reload value, starts count
// - Wrap to all ones: underflow, stop, hold
// - Match before underflow reloads and restarts
// - Dead time lasts reload plus one clocks
// - Dead time off: plain true/complement pairs, both low in interval mode
// - Dead-time counters hidden, reset to ones
// - One shared reload, independent counters
// - Reload 16-bit access, low 10 bits
// - Phase compare equality sets output flip-flop per mode, toggles it only in interval mode
// - Each phase compare has its own buffer
// - Phase compares are 16-bit read/write
// - Direct-write bit: writes go straight in
// - Direct-write clear: write moves buffers in
// - Period sets limit, reverses or clears
`ifndef IPW_DEFINES_SVH
`define IPW_DEFINES_SVH

// Byte offsets on the register bus
`define IPW_OFF_CTRL    8'h00
`define IPW_OFF_STATUS  8'h04
`define IPW_OFF_COUNT   8'h08
`define IPW_OFF_PERIOD  8'h0c
`define IPW_OFF_RELOAD  8'h10
`define IPW_OFF_CMP_A   8'h14
`define IPW_OFF_BUF_A   8'h20

// Control register fields
`define IPW_CTRL_RUN    0
`define IPW_CTRL_MODE_LO 1
`define IPW_CTRL_MODE_HI 3
`define IPW_CTRL_DTEN   4
`define IPW_CTRL_DIRWR  5

// Status register fields
`define IPW_STAT_UP     0
`define IPW_STAT_UFL_LO 1

// Reset values
`define IPW_COUNT_RST   16'h0000
`define IPW_DT_IDLE     10'h3ff
`define IPW_REG_RST     16'h0000

`endif

//--- rtl/ipw_pkg.sv
// Types shared by the inverter PWM timer
package ipw_pkg;

  // Operating modes of the main counter
  typedef enum logic [2:0] {
    IPW_INTERVAL = 3'h0,
    IPW_SYM_TRI  = 3'h1,
    IPW_ASYM_TRI = 3'h3,
    IPW_SAWTOOTH = 3'h2,
    IPW_PWM_ONE  = 3'h6
  } ipw_mode_type;

  // Avalon-MM request from the bus master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ipw_av_req_type;

endpackage : ipw_pkg

//--- rtl/ipw_timer.sv
// Inverter PWM timer with phase compares and dead-time counters
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "ipw_defines.svh"

module ipw_timer
  import ipw_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           reset_n,
  // Avalon-MM slave
  input  wire ipw_av_req_type av_req,
  output logic                waitrequest,
  output logic [31:0]         readdata,
  // PWM output pairs, true on even bits
  output logic [5:0]          pwm_out
);

  // Full 16-bit lane check for halfword-only registers
  function automatic logic lanes16(input logic [3:0] be);
    lanes16 = (be[1:0] == 2'b11);
  endfunction : lanes16

  // Channel index of a compare or buffer address
  function automatic logic [1:0] chan(input logic [7:0] a,
                                      input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    chan = d[3:2];
  endfunction : chan

  logic               run;
  ipw_mode_type       mode;
  logic               dt_en;
  logic               dir_wr;
  logic [15:0]        main_counter;
  logic               count_up;
  logic [15:0]        period_compare_reg;
  logic [9:0]         dead_time_reload;
  logic [15:0]        phase_compare_regs [3];
  logic [15:0]        phase_compare_buffers [3];
  logic [9:0]         dead_time_counters [3];
  logic [2:0]         phase;
  logic [2:0]         ufl_sticky;
  logic [2:0]         match;
  logic [2:0]         underflow;
  logic               period_match_event;
  logic               counter_turnaround_event;
  logic               clr_mode;
  logic               tri_mode;
  logic               xfer;
  logic               wr_go;
  logic               sw_xfer;
  logic [7:0]         addr;
  logic [15:0]        wdata;
  logic [31:0]        next_readdata;

  assign addr  = av_req.address;
  assign wdata = av_req.writedata[15:0];
  assign wr_go = av_req.write && !waitrequest;

  // Mode groups
  assign clr_mode = (mode == IPW_INTERVAL) || (mode == IPW_SAWTOOTH)
                    || (mode == IPW_PWM_ONE);
  assign tri_mode = (mode == IPW_SYM_TRI) || (mode == IPW_ASYM_TRI);

  // Counter events
  assign period_match_event = run && count_up
                              && (main_counter == period_compare_reg);
  assign counter_turnaround_event = run && tri_mode && !count_up
                                    && (main_counter == `IPW_COUNT_RST);

  // Buffer-to-compare transfer timing per mode
  always_comb
  begin
    case (mode)
      IPW_SYM_TRI:  xfer = counter_turnaround_event;
      IPW_ASYM_TRI: xfer = counter_turnaround_event
                           || period_match_event;
      IPW_SAWTOOTH,
      IPW_PWM_ONE:  xfer = period_match_event;
      default:      xfer = 1'b0;
    endcase
  end

  // Software write to a compare with direct write off
  assign sw_xfer = wr_go && lanes16(av_req.byteenable) && !dir_wr
                   && addr >= `IPW_OFF_CMP_A
                   && addr < `IPW_OFF_BUF_A;

  // Continuous compare of each phase against the counter
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      match[i] = run && (phase_compare_regs[i] == main_counter);
      underflow[i] = dt_en && (dead_time_counters[i] == 10'h000)
                     && !match[i];
    end
  end

  // Bus handshake: one wait state, then acknowledge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      waitrequest <= 1'b1;
    else if (waitrequest && (av_req.read || av_req.write))
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // Read data multiplexer
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (addr == `IPW_OFF_CTRL)
      next_readdata[5:0] = {dir_wr, dt_en, mode, run};
    else if (addr == `IPW_OFF_STATUS)
      next_readdata[3:0] = {ufl_sticky, count_up};
    else if (addr == `IPW_OFF_COUNT)
      next_readdata[15:0] = main_counter;
    else if (addr == `IPW_OFF_PERIOD)
      next_readdata[15:0] = period_compare_reg;
    else if (addr == `IPW_OFF_RELOAD)
      next_readdata[9:0] = dead_time_reload;
    else if (addr >= `IPW_OFF_CMP_A && addr < `IPW_OFF_BUF_A
             && addr[1:0] == 2'b00)
      next_readdata[15:0] =
        phase_compare_regs[chan(addr, `IPW_OFF_CMP_A)];
    else if (addr >= `IPW_OFF_BUF_A && addr < 8'h2c
             && addr[1:0] == 2'b00)
      next_readdata[15:0] =
        phase_compare_buffers[chan(addr, `IPW_OFF_BUF_A)];
  end

  // Read data captured during the wait state
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      readdata <= 32'h0000_0000;
    else if (waitrequest && av_req.read)
      readdata <= next_readdata;
  end

  // Control register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run    <= 1'b0;
      mode   <= IPW_INTERVAL;
      dt_en  <= 1'b0;
      dir_wr <= 1'b0;
    end
    else if (wr_go && addr == `IPW_OFF_CTRL && av_req.byteenable[0])
    begin
      run    <= av_req.writedata[`IPW_CTRL_RUN];
      mode   <= ipw_mode_type'(
                av_req.writedata[`IPW_CTRL_MODE_HI:`IPW_CTRL_MODE_LO]);
      dt_en  <= av_req.writedata[`IPW_CTRL_DTEN];
      dir_wr <= av_req.writedata[`IPW_CTRL_DIRWR];
    end
  end

  // Period and shared reload registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      period_compare_reg <= `IPW_REG_RST;
      dead_time_reload   <= 10'h000;
    end
    else if (wr_go && lanes16(av_req.byteenable))
    begin
      if (addr == `IPW_OFF_PERIOD)
        period_compare_reg <= wdata;
      else if (addr == `IPW_OFF_RELOAD)
        dead_time_reload <= wdata[9:0];
    end
  end

  // Main counter, no bus write path
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_counter <= `IPW_COUNT_RST;
      count_up     <= 1'b1;
    end
    else if (!run)
      count_up <= 1'b1;
    else if (clr_mode)
    begin
      count_up <= 1'b1;
      if (period_match_event)
        main_counter <= `IPW_COUNT_RST;
      else
        main_counter <= main_counter + 16'h0001;
    end
    else if (period_match_event)
    begin
      count_up     <= 1'b0;
      main_counter <= main_counter - 16'h0001;
    end
    else if (counter_turnaround_event)
    begin
      count_up     <= 1'b1;
      main_counter <= main_counter + 16'h0001;
    end
    else if (count_up)
      main_counter <= main_counter + 16'h0001;
    else
      main_counter <= main_counter - 16'h0001;
  end

  // Phase buffers and compare registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        phase_compare_regs[i]    <= `IPW_REG_RST;
        phase_compare_buffers[i] <= `IPW_REG_RST;
      end
    end
    else
    begin
      if (xfer)
        for (int i = 0; i < 3; i++)
          phase_compare_regs[i] <= phase_compare_buffers[i];
      if (sw_xfer)
        for (int i = 0; i < 3; i++)
          phase_compare_regs[i] <= phase_compare_buffers[i];
      if (wr_go && lanes16(av_req.byteenable) && addr[1:0] == 2'b00)
      begin
        if (dir_wr && addr >= `IPW_OFF_CMP_A && addr < `IPW_OFF_BUF_A)
          phase_compare_regs[chan(addr, `IPW_OFF_CMP_A)]
            <= wdata;
        else if (addr >= `IPW_OFF_BUF_A && addr < 8'h2c)
          phase_compare_buffers[chan(addr, `IPW_OFF_BUF_A)] <= wdata;
      end
    end
  end

  // Output flip-flops driven by compare triggers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      phase <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
      begin
        if (!run)
          phase[i] <= 1'b0;
        else if (match[i])
        begin
          if (tri_mode)
            phase[i] <= count_up;
          else if (clr_mode && mode != IPW_INTERVAL)
            phase[i] <= 1'b1;
          else
            phase[i] <= !phase[i];
        end
        else if (period_match_event && mode != IPW_INTERVAL
                 && clr_mode)
          phase[i] <= 1'b0;
      end
  end

  // Dead-time one-shots, clocked every system clock
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      for (int i = 0; i < 3; i++)
        dead_time_counters[i] <= `IPW_DT_IDLE;
    else
      for (int i = 0; i < 3; i++)
      begin
        if (!dt_en)
          dead_time_counters[i] <= `IPW_DT_IDLE;
        else if (match[i])
          dead_time_counters[i] <= dead_time_reload;
        else if (dead_time_counters[i] != `IPW_DT_IDLE)
          dead_time_counters[i] <= dead_time_counters[i]
                                   - 10'h001;
      end
  end

  // Sticky underflow flags, write one to clear, set wins
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ufl_sticky <= 3'h0;
    else if (wr_go && addr == `IPW_OFF_STATUS && av_req.byteenable[0])
      ufl_sticky <= (ufl_sticky & ~av_req.writedata[3:1]) | underflow;
    else
      ufl_sticky <= ufl_sticky | underflow;
  end

  // Pair outputs with dead-time gap while a one-shot runs
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pwm_out <= 6'h00;
    else
      for (int i = 0; i < 3; i++)
      begin
        if (!run || mode == IPW_INTERVAL)
          pwm_out[2*i +: 2] <= 2'b00;
        else if (!dt_en)
          pwm_out[2*i +: 2] <= {!phase[i], phase[i]};
        else if (dead_time_counters[i] != `IPW_DT_IDLE || match[i])
          pwm_out[2*i +: 2] <= 2'b00;
        else
          pwm_out[2*i +: 2] <= {!phase[i], phase[i]};
      end
  end

  // Checks
  sequence bus_req_s;
    (av_req.read || av_req.write) && waitrequest;
  endsequence

  sequence dt_start_s;
    dt_en && match[0];
  endsequence

  bus_ack_a: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_req_s |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one wait state");

  count_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    period_match_event && clr_mode |=> main_counter == 16'h0000)
    else $error("counter not cleared at period match");

  tri_reverse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    period_match_event && tri_mode && run |=> !count_up
      && main_counter == $past(period_compare_reg) - 16'h0001)
    else $error("triangle did not reverse at period");

  count_ro_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_go && addr == `IPW_OFF_COUNT && !run |=> $stable(main_counter))
    else $error("counter changed by a bus write");

  dt_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dt_start_s |=> dead_time_counters[0] == $past(dead_time_reload))
    else $error("dead time not loaded at match");

  dt_wrap_a: assert property (@(posedge mclk) disable iff (!reset_n)
    underflow[0] |=> dead_time_counters[0] == 10'h3ff
      ##1 (dead_time_counters[0] == 10'h3ff || $past(match[0])))
    else $error("dead time did not wrap and hold");

  dt_width_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dt_start_s ##1 (dead_time_counters[0] == 10'h002 && dt_en
      && match[0] == 1'b0) [*1] ##1 (!match[0] && dt_en) [*2]
      |=> dead_time_counters[0] == 10'h3ff)
    else $error("dead time width off");

  // One step down per clock while a one-shot runs, for any reload
  dt_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dt_en && !match[0] && dead_time_counters[0] != 10'h3ff
      |=> dead_time_counters[0] == $past(dead_time_counters[0]) - 10'h001)
    else $error("dead time count step off");

  buf_xfer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    xfer && !wr_go |=> phase_compare_regs[1] ==
      $past(phase_compare_buffers[1]))
    else $error("buffer not moved to compare");

  no_gap_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run && !dt_en && mode != IPW_INTERVAL |=> pwm_out[1] == !pwm_out[0])
    else $error("pair not complementary without dead time");

endmodule : ipw_timer
`default_nettype wire

//--- testbench/ipw_switch_model.sv
// Switch driver model: dead-time gap and shoot-through watch
`timescale 1ns/100ps
`default_nettype none

module ipw_switch_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Gate drive pins
  input  wire logic [5:0]  pwm,
  // Measurements
  output logic             gap_valid,
  output logic [15:0]      gap,
  output logic [7:0]       shoot
);
  logic [15:0] cnt;
  logic        last_lo;

  // Both-off width before true side of pair a turns on
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt       <= 16'h0;
      last_lo   <= 1'b0;
      gap_valid <= 1'b0;
      gap       <= 16'h0;
    end
    else
    begin
      gap_valid <= 1'b0;
      cnt       <= (pwm[1:0] == 2'h0) ? cnt + 16'h1 : 16'h0;
      if (pwm[1])
        last_lo <= 1'b1;
      else if (pwm[0])
        last_lo <= 1'b0;
      if (pwm[0] && cnt != 16'h0 && last_lo)
      begin
        gap_valid <= 1'b1;
        gap       <= cnt;
      end
    end
  end

  // Both switches of one leg on at once
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      shoot <= 8'h0;
    else if ((pwm[0] & pwm[1]) | (pwm[2] & pwm[3]) | (pwm[4] & pwm[5]))
      shoot <= shoot + 8'h1;
  end
endmodule : ipw_switch_model
`default_nettype wire

//--- testbench/inverter_pwm_timer_dead_time_bench.sv
// Self-checking bench of the inverter PWM timer
`timescale 1ns/100ps
`default_nettype none
`include "ipw_defines.svh"

module inverter_pwm_timer_dead_time_bench
  import ipw_pkg::*;
  ;
  // Design and model signals
  logic           mclk;
  logic           reset_n;
  ipw_av_req_type av_req;
  logic           waitrequest;
  logic [31:0]    readdata;
  logic [5:0]     pwm_out;
  logic           gap_valid;
  logic [15:0]    gap;
  logic [7:0]     shoot;
  // Notes of expected results
  logic [31:0]    q_lo[$];
  logic [31:0]    q_hi[$];
  logic [31:0]    q_msk[$];
  logic [15:0]    gap_lo;
  logic [15:0]    gap_hi;
  logic           gap_on;
  int             n_gaps;
  int             n_mismatch;
  int             n_checks;
  logic [31:0]    rnd;
  logic [9:0]     dt;
  logic [15:0]    bv[3];
  ipw_mode_type   modes[5] = '{IPW_INTERVAL, IPW_SYM_TRI, IPW_ASYM_TRI,
                               IPW_SAWTOOTH, IPW_PWM_ONE};

  ipw_timer ipw_timer_inst (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .av_req      (av_req),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .pwm_out     (pwm_out)
  );

  ipw_switch_model ipw_switch_model_inst (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pwm       (pwm_out),
    .gap_valid (gap_valid),
    .gap       (gap),
    .shoot     (shoot)
  );

  // System clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Xorshift stimulus source
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // Control word from its fields
  function automatic logic [31:0] ctl(input logic r, input ipw_mode_type m,
                                      input logic d, input logic w);
    return {26'h0, w, d, m, r};
  endfunction : ctl

  // Verdict and end of run
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Count and print a mismatch
  task automatic fail(input string s);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : fail

  // One Avalon transfer, held until waitrequest low
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge mclk);
    av_req <= '{rd, ~rd, a, 4'hf, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (waitrequest === 1'b0)
        break;
    end
    av_req <= '0;
    if (i == 20)
    begin
      fail("bus timeout");
      results();
    end
  endtask : bus

  // Write one register
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr

  // Read, noting the window of (data & m)
  task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                    input logic [31:0] hi, input logic [31:0] m);
    q_lo.push_back(lo);
    q_hi.push_back(hi);
    q_msk.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask : rd

  // Read with an exact expectation
  task automatic rdx(input logic [7:0] a, input logic [31:0] v);
    rd(a, v, v, 32'hffffffff);
  endtask : rdx

  // Compare read data with its note
  task automatic cmp_rd(input logic [31:0] lo, input logic [31:0] hi,
                        input logic [31:0] m);
    logic [31:0] v;
    v = readdata & m;
    n_checks++;
    if ((v >= lo && v <= hi) !== 1'b1)
      fail("read data");
  endtask : cmp_rd

  // Compare a measured dead-time gap
  task automatic cmp_gap(input logic [15:0] g);
    n_checks++;
    n_gaps++;
    if ((g >= gap_lo && g <= gap_hi) !== 1'b1)
      fail("dead time width");
  endtask : cmp_gap

  // Compare the three pairs for true and complement
  task automatic cmp_pair;
    int j;
    for (j = 0; j < 3; j++)
    begin
      n_checks++;
      if (pwm_out[2*j+1] !== ~pwm_out[2*j])
        fail("pair not complementary");
    end
  endtask : cmp_pair

  // Watch answers and gaps as they appear
  always @(posedge mclk)
  begin
    if (av_req.read && waitrequest === 1'b0)
    begin
      if (q_lo.size() == 0)
        fail("read without note");
      else
        cmp_rd(q_lo.pop_front(), q_hi.pop_front(), q_msk.pop_front());
    end
    if (gap_on && gap_valid === 1'b1)
      cmp_gap(gap);
  end

  // Main sequence
  initial
  begin
    int i;
    int k;
    av_req = '0;
    reset_n = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    n_gaps = 0;
    gap_on = 1'b0;
    rnd = 32'h34;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset value, ignored counter write, reload width, hole
    rdx(`IPW_OFF_COUNT, 32'h0);
    wr(`IPW_OFF_COUNT, 32'h1234);
    rdx(`IPW_OFF_COUNT, 32'h0);
    wr(`IPW_OFF_RELOAD, 32'hffff);
    rdx(`IPW_OFF_RELOAD, 32'h3ff);
    rdx(8'h3c, 32'h0);
    // Direct compare writes, then buffered transfer
    wr(`IPW_OFF_CTRL, ctl(1'b0, IPW_INTERVAL, 1'b0, 1'b1));
    for (i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      bv[i] = ~rnd[15:0];
      wr(8'(`IPW_OFF_CMP_A + 4 * i), {16'h0, rnd[15:0]});
      rdx(8'(`IPW_OFF_CMP_A + 4 * i), {16'h0, rnd[15:0]});
      wr(8'(`IPW_OFF_BUF_A + 4 * i), {16'h0, bv[i]});
    end
    wr(`IPW_OFF_CTRL, ctl(1'b0, IPW_INTERVAL, 1'b0, 1'b0));
    wr(`IPW_OFF_CMP_A, 32'h5a5a);
    for (i = 0; i < 3; i++)
      rdx(8'(`IPW_OFF_CMP_A + 4 * i), {16'h0, bv[i]});
    // Every mode keeps the count within the period
    wr(`IPW_OFF_PERIOD, 32'h1e);
    for (k = 0; k < 5; k++)
    begin
      wr(`IPW_OFF_CTRL, ctl(1'b1, modes[k], 1'b0, 1'b1));
      for (i = 0; i < 4; i++)
      begin
        rnd = xs(rnd);
        repeat (rnd[5:0]) @(posedge mclk);
        rd(`IPW_OFF_COUNT, 32'h0, 32'h1e, 32'hffffffff);
      end
      @(negedge mclk);
      if (k > 0 && k < 4)
        cmp_pair();
      wr(`IPW_OFF_CTRL, ctl(1'b0, modes[k], 1'b0, 1'b1));
    end
    // Sawtooth with dead time of random reload
    rnd = xs(rnd);
    dt = 10'(2 + rnd[2:0]);
    gap_lo = 16'(dt) + 16'h1;
    gap_hi = 16'(dt) + 16'h4;
    wr(`IPW_OFF_RELOAD, {22'h0, dt});
    wr(`IPW_OFF_PERIOD, 32'h28);
    // Buffer too, so period transfers keep the phase a compare
    wr(`IPW_OFF_BUF_A, 32'h0a);
    wr(`IPW_OFF_CMP_A, 32'h0a);
    gap_on = 1'b1;
    wr(`IPW_OFF_CTRL, ctl(1'b1, IPW_SAWTOOTH, 1'b1, 1'b1));
    repeat (400) @(posedge mclk);
    rd(`IPW_OFF_STATUS, 32'h3, 32'h3, 32'h3);
    wr(`IPW_OFF_CTRL, ctl(1'b0, IPW_SAWTOOTH, 1'b1, 1'b1));
    gap_on = 1'b0;
    n_checks++;
    if (n_gaps == 0)
      fail("no dead time seen");
    n_checks++;
    if (shoot !== 8'h0)
      fail("pair shoot-through");
    results();
  end
endmodule : inverter_pwm_timer_dead_time_bench
`default_nettype wire
